// ==== hw/fault_dispatch_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fdu_regs.svh"
module fault_dispatch_unit
   import fdu_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // register bus
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // memory port
   output logic             mem_read,
   output logic             mem_write,
   output logic      [31:0] mem_address,
   output logic      [15:0] mem_writedata,
   input  wire logic [15:0] mem_readdata,
   input  wire logic        mem_waitrequest,
   // fault sources
   input  wire logic [31:0] cur_pc,
   input  wire logic        priv_instr,
   input  wire logic        dispatch,
   input  wire logic [15:0] proc_blk_word4,
   input  wire logic        xlate_ref,
   input  wire logic        page_present,
   input  wire logic        access_ok,
   input  wire logic        seg_out_range,
   input  wire logic        seg_absent,
   input  wire logic        decode_unimpl,
   input  wire logic        decode_illegal,
   input  wire logic        sem_overflow,
   input  wire logic        sem_underflow,
   input  wire logic        stack_over,
   input  wire logic        stack_under,
   input  wire logic        arg_ptr,
   input  wire logic        ptr_fault_bit,
   input  wire logic [15:0] fault_info_code,
   input  wire logic [31:0] fault_info_addr,
   input  wire logic        arith_exc,
   input  wire logic [3:0]  arith_sel,
   input  wire logic [31:0] arith_addr,
   input  wire logic        carry_clear,
   // instruction events
   input  wire logic        fault_call_instr,
   input  wire logic        procedure_return_instr,
   input  wire logic        instr_retire,
   // control outputs
   output logic             redirect_valid,
   output logic      [31:0] redirect_pc,
   output logic             int_block,
   output logic             segmented_v_mode,
   output logic             busy,
   output logic             carry_flag
);

   st_t         s;
   st_t         next_s;
   logic [10:0] req;
   fault_t      fsel;
   logic        fvalid;
   logic        step;
   logic [31:0] rv;

   function automatic logic [15:0] code_of(input logic [3:0] sel);
      logic [15:0] c;
      c = 16'h0000;
      unique case (sel)
         4'h0: c = 16'h0100;
         4'h1: c = 16'h0101;
         4'h2: c = 16'h0102;
         4'h3: c = 16'h0103;
         4'h4: c = 16'h0500;
         4'h5: c = 16'h0200;
         4'h6: c = 16'h0201;
         4'h7: c = 16'h0600;
         4'h8: c = 16'h0300;
         4'h9: c = 16'h0301;
         4'ha: c = 16'h0700;
         4'hb: c = 16'h0701;
         4'hc: c = 16'h0702;
         4'hd: c = 16'h0800;
         4'he: c = 16'h0801;
         4'hf: c = 16'h0803;
      endcase
      return c;
   endfunction : code_of

   function automatic logic serves(input logic [3:0] sel, input logic [15:0] k);
      logic v;
      v = 1'b0;
      if (sel == 4'h8 || sel == 4'h9)
         v = k[`FDU_KEY_INT];
      else if (sel >= 4'ha && sel <= 4'hc)
         v = k[`FDU_KEY_DEC];
      else
         v = !k[`FDU_KEY_FLOAT];
      return v;
   endfunction : serves

   function automatic logic [4:0] last_of(input st_t x);
      logic [4:0] l;
      l = `FDU_LAST_PAIR;
      if (x.state == st_hid || x.state == st_hrd)
         l = `FDU_LAST_HID;
      else if (x.state == st_pfr)
         l = `FDU_LAST_PFR;
      else if (x.state == st_vec && !x.facility)
         l = 5'h00;
      return l;
   endfunction : last_of

   function automatic logic [49:0] beat(input st_t x);
      logic [31:0] a;
      logic [15:0] d;
      logic        rd;
      logic        wr;
      a  = 32'h0;
      d  = 16'h0;
      rd = 1'b0;
      wr = 1'b0;
      unique case (x.state)
         st_hid: begin
            wr = 1'b1;
            a  = x.nxt + 32'(x.idx);
            unique case (x.idx)
               5'h00:   d = x.saved[31:16];
               5'h01:   d = x.saved[15:0];
               5'h02:   d = x.keys;
               5'h03:   d = x.fch;
               5'h04:   d = x.fad[31:16];
               default: d = x.fad[15:0];
            endcase
         end
         st_vec: begin
            rd = 1'b1;
            a  = x.facility ? x.vec + 32'(x.idx) : x.vec + 32'(x.ftype);
         end
         st_entry: begin
            rd = 1'b1;
            a  = x.pbase + `FDU_ENTRY_PTR + 32'(x.idx);
         end
         st_hrd: begin
            rd = 1'b1;
            a  = x.frame + 32'(x.idx);
         end
         st_pfr: begin
            wr = 1'b1;
            a  = x.sp + 32'(x.idx);
            unique case (x.idx)
               5'h00:   d = `FDU_FLAG_SET;
               5'h01:   d = x.root;
               5'h02:   d = x.hbuf[0];
               5'h03:   d = x.hbuf[1];
               5'h04:   d = x.sbase[31:16];
               5'h05:   d = x.sbase[15:0];
               5'h06:   d = x.lbase[31:16];
               5'h07:   d = x.lbase[15:0];
               5'h08:   d = x.hbuf[2];
               5'h09:   d = x.pbase[15:0] + `FDU_FOLLOW;
               5'h0a:   d = x.hbuf[3];
               5'h0b:   d = x.hbuf[4];
               5'h0c:   d = x.hbuf[5];
               default: d = 16'h0;
            endcase
         end
         st_ret: begin
            rd = 1'b1;
            a  = x.sp + `FDU_RET_OFF + 32'(x.idx);
         end
         default: begin
            rd = 1'b0;
         end
      endcase
      return {rd, wr, a, d};
   endfunction : beat

   // fault detection
   always_comb begin
      req     = '0;
      req[0]  = priv_instr && s.ring != 2'b00 && s.restricted;
      req[1]  = dispatch && proc_blk_word4 != 16'h0;
      req[2]  = xlate_ref && !page_present;
      req[3]  = decode_unimpl;
      req[4]  = sem_overflow || sem_underflow;
      req[5]  = decode_illegal;
      req[6]  = xlate_ref && !access_ok;
      req[7]  = arith_exc && serves(arith_sel, s.keys);
      req[8]  = stack_over || stack_under;
      req[9]  = xlate_ref && (seg_out_range || seg_absent);
      req[10] = arg_ptr && ptr_fault_bit;
      fvalid  = |req;
      fsel    = f_restrict;
      for (int i = 10; i >= 0; i--) begin
         if (req[i])
            fsel = fault_t'(4'(i));
      end
   end

   // register read data
   always_comb begin
      rv = 32'h0;
      unique case (avs_address)
         `FDU_REG_CTRL:   rv = {26'h0, s.segmented, s.h_ring0, s.ring, s.restricted, s.facility};
         `FDU_REG_KEYS:   rv = {16'h0, s.keys};
         `FDU_REG_STATUS: rv = {24'h0, s.ftype, s.int_block, s.segmented, busy, s.carry};
         `FDU_REG_FCH:    rv = {16'h0, s.fch};
         `FDU_REG_FCL:    rv = {16'h0, s.fcl};
         `FDU_REG_FAULT_ADDR: rv = s.fad;
         `FDU_REG_SAVED:  rv = s.saved;
         `FDU_REG_VECTOR: rv = s.vec;
         `FDU_REG_NEXT:   rv = s.nxt;
         `FDU_REG_FIRST:  rv = s.first;
         `FDU_REG_LAST:   rv = s.last;
         `FDU_REG_SP:     rv = s.sp;
         `FDU_REG_PBASE:  rv = s.pbase;
         `FDU_REG_SBASE:  rv = s.sbase;
         `FDU_REG_LBASE:  rv = s.lbase;
         `FDU_REG_ROOT:   rv = {16'h0, s.root};
         default:         rv = 32'h0;
      endcase
   end

   always_comb begin
      next_s       = s;
      next_s.redir = 1'b0;
      step         = (s.mem_rd || s.mem_wr) && !mem_waitrequest;
      // bus slave, answers on second cycle
      next_s.ack = (avs_read || avs_write) && !s.ack;
      if (avs_read && !s.ack)
         next_s.rdata = rv;
      if (avs_write && s.ack) begin
         unique case (avs_address)
            `FDU_REG_CTRL: begin
               next_s.facility   = avs_writedata[0];
               next_s.restricted = avs_writedata[1];
               next_s.ring       = avs_writedata[3:2];
               next_s.h_ring0    = avs_writedata[4];
               next_s.segmented  = avs_writedata[5];
            end
            `FDU_REG_KEYS:   next_s.keys  = avs_writedata[15:0];
            `FDU_REG_STATUS: begin
               if (avs_writedata[0])
                  next_s.carry = 1'b0;
            end
            `FDU_REG_FCH:    next_s.fch   = avs_writedata[15:0];
            `FDU_REG_FCL:    next_s.fcl   = avs_writedata[15:0];
            `FDU_REG_FAULT_ADDR: next_s.fad = avs_writedata;
            `FDU_REG_SAVED:  next_s.saved = avs_writedata;
            `FDU_REG_VECTOR: next_s.vec   = avs_writedata;
            `FDU_REG_NEXT:   next_s.nxt   = avs_writedata;
            `FDU_REG_FIRST:  next_s.first = avs_writedata;
            `FDU_REG_LAST:   next_s.last  = avs_writedata;
            `FDU_REG_SP:     next_s.sp    = avs_writedata;
            `FDU_REG_SBASE:  next_s.sbase = avs_writedata;
            `FDU_REG_LBASE:  next_s.lbase = avs_writedata;
            `FDU_REG_ROOT:   next_s.root  = avs_writedata[15:0];
            default:         next_s.root  = s.root;
         endcase
      end
      // carry: clears first, a new exception wins
      if (carry_clear)
         next_s.carry = 1'b0;
      if (arith_exc)
         next_s.carry = 1'b1;
      if (instr_retire)
         next_s.int_block = 1'b0;
      // sequencer
      if (fvalid && (s.state == st_idle || s.state == st_armed)) begin
         next_s.ftype = fsel;
         next_s.saved = cur_pc;
         next_s.idx   = 5'h0;
         if (fsel == f_arith) begin
            next_s.fch = code_of(arith_sel);
            next_s.fcl = `FDU_FAULT_CODE_LOW_ARITH;
            next_s.fad = (arith_sel == `FDU_SEL_INT_OVF) ? 32'h0 : arith_addr;
         end else begin
            next_s.fch = fault_info_code;
            next_s.fad = fault_info_addr;
         end
         next_s.state = s.facility ? st_hid : st_vec;
      end else begin
         unique case (s.state)
            st_idle: begin
               if (procedure_return_instr) begin
                  next_s.sp    = s.sp - `FDU_PFR_WORDS;
                  next_s.idx   = 5'h0;
                  next_s.state = st_ret;
               end
            end
            st_armed: begin
               if (fault_call_instr) begin
                  next_s.idx   = 5'h0;
                  next_s.state = st_entry;
               end
            end
            default: begin
               if (step) begin
                  next_s.idx = s.idx + 5'h1;
                  unique case (s.state)
                     st_vec: next_s.tmp = {s.tmp[15:0], mem_readdata};
                     st_entry: next_s.tmp = {s.tmp[15:0], mem_readdata};
                     st_ret: next_s.tmp = {s.tmp[15:0], mem_readdata};
                     st_hrd: next_s.hbuf[s.idx[2:0]] = mem_readdata;
                     default: next_s.tmp = s.tmp;
                  endcase
                  if (s.idx == last_of(s)) begin
                     next_s.idx = 5'h0;
                     unique case (s.state)
                        st_hid: begin
                           if (s.nxt == s.last)
                              next_s.nxt = s.first;
                           else
                              next_s.nxt = s.nxt + `FDU_HID_WORDS;
                           next_s.segmented = 1'b1;
                           next_s.state     = st_vec;
                        end
                        st_vec: begin
                           next_s.redir = 1'b1;
                           if (s.h_ring0)
                              next_s.int_block = 1'b1;
                           if (s.facility) begin
                              next_s.pbase = {s.tmp[15:0], mem_readdata}
                                 + (32'(s.ftype) << `FDU_ENTRY_SHIFT);
                              next_s.redir_pc = next_s.pbase;
                              next_s.state    = st_armed;
                           end else begin
                              next_s.redir_pc = {16'h0, mem_readdata};
                              next_s.state    = st_idle;
                           end
                        end
                        st_entry: begin
                           if (s.nxt == s.first)
                              next_s.frame = s.last;
                           else
                              next_s.frame = s.nxt - `FDU_HID_WORDS;
                           next_s.state = st_hrd;
                        end
                        st_hrd: next_s.state = st_pfr;
                        st_pfr: begin
                           next_s.nxt      = s.frame;
                           next_s.sp       = s.sp + `FDU_PFR_WORDS;
                           next_s.redir    = 1'b1;
                           next_s.redir_pc = s.tmp;
                           next_s.state    = st_idle;
                        end
                        default: begin
                           next_s.redir    = 1'b1;
                           next_s.redir_pc = {s.tmp[15:0], mem_readdata};
                           next_s.state    = st_idle;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
      {next_s.mem_rd, next_s.mem_wr, next_s.mem_addr, next_s.mem_wd} = beat(next_s);
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         s <= '0;
      else if (ce)
         s <= next_s;
   end

   assign avs_waitrequest  = (avs_read || avs_write) && !s.ack;
   assign avs_readdata     = s.rdata;
   assign mem_read         = s.mem_rd;
   assign mem_write        = s.mem_wr;
   assign mem_address      = s.mem_addr;
   assign mem_writedata    = s.mem_wd;
   assign redirect_valid   = s.redir;
   assign redirect_pc      = s.redir_pc;
   assign int_block        = s.int_block;
   assign segmented_v_mode = s.segmented;
   assign busy             = s.state != st_idle;
   assign carry_flag       = s.carry;

endmodule : fault_dispatch_unit
`default_nettype wire

// ==== hw/fdu_pkg.sv ====
package fdu_pkg;
   typedef enum logic [3:0] {
      st_idle  = 4'h0,
      st_hid   = 4'h1,
      st_vec   = 4'h3,
      st_armed = 4'h2,
      st_entry = 4'h6,
      st_hrd   = 4'h7,
      st_pfr   = 4'h5,
      st_ret   = 4'h4
   } state_t;
   typedef enum logic [3:0] {
      f_restrict, f_process, f_page, f_unimpl, f_sem, f_illegal,
      f_access, f_arith, f_stack, f_segment, f_pointer
   } fault_t;
   typedef struct packed {
      state_t             state;
      logic [4:0]         idx;
      fault_t             ftype;
      logic               facility, restricted, h_ring0, segmented;
      logic [1:0]         ring;
      logic [15:0]        keys, fch, fcl, root;
      logic               carry, int_block, redir, mem_rd, mem_wr, ack;
      logic [31:0]        fad, saved, vec, nxt, first, last, sp, pbase;
      logic [31:0]        sbase, lbase, tmp, frame, redir_pc, mem_addr, rdata;
      logic [5:0][15:0]   hbuf;
      logic [15:0]        mem_wd;
   } st_t;
endpackage : fdu_pkg

// ==== hw/fdu_regs.svh ====
// Summary of operation
// - facility off: save counter, mask, indirect jump
// - facility on: frame, segmented mode, vector, base
// - write hidden frame, then advance next pointer
// - entry address is table start plus type offset
// - ring zero handler blocks interrupts one instruction
// - fault call builds procedure frame from hidden frame
// - pop hidden frame, flag one, branch to entry
// - procedure frame word layout fixed, sixteen words
// - return resumes at frame words two and three
// - privileged op outside ring zero when restricted
// - dispatch with nonzero control block word four
// - reference to page not present
// - unimplemented and illegal opcodes fault separately
// - semaphore count overflow or underflow
// - segment referenced without access rights
// - segment number too large or segment absent
// - stack over/underflow; pointer fault bit set
// - key bits 7, 8, 11 pick actions
// - integer/decimal: bit clear carry only, set services
// - float: bit set carry only, clear services
// - low code octal 50; address loaded, zero for integer overflow
// - high code identifies the exception
// - table entry eight bytes, handler pointer bytes 3-6
// - hidden stack wraps, newest overwrites oldest
`ifndef FDU_REGS_SVH
`define FDU_REGS_SVH
`define FDU_REG_CTRL    6'h00
`define FDU_REG_KEYS    6'h04
`define FDU_REG_STATUS  6'h08
`define FDU_REG_FCH     6'h0c
`define FDU_REG_FCL     6'h10
`define FDU_REG_FAULT_ADDR 6'h14
`define FDU_REG_SAVED   6'h18
`define FDU_REG_VECTOR  6'h1c
`define FDU_REG_NEXT    6'h20
`define FDU_REG_FIRST   6'h24
`define FDU_REG_LAST    6'h28
`define FDU_REG_SP      6'h2c
`define FDU_REG_PBASE   6'h30
`define FDU_REG_SBASE   6'h34
`define FDU_REG_LBASE   6'h38
`define FDU_REG_ROOT    6'h3c
`define FDU_KEY_FLOAT   7
`define FDU_KEY_INT     8
`define FDU_KEY_DEC     11
`define FDU_FAULT_CODE_LOW_ARITH 16'h0028
`define FDU_FLAG_SET    16'h0001
`define FDU_HID_WORDS   32'h00000006
`define FDU_PFR_WORDS   32'h00000010
`define FDU_ENTRY_SHIFT 2
`define FDU_ENTRY_PTR   32'h00000001
`define FDU_FOLLOW      16'h0003
`define FDU_RET_OFF     32'h00000002
`define FDU_LAST_HID    5'h05
`define FDU_LAST_PFR    5'h0f
`define FDU_LAST_PAIR   5'h01
`define FDU_SEL_INT_OVF 4'h8
`endif

// ==== testbench/fdu_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdu_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        ce,
   // watched inputs
   input wire logic        avs_write,
   input wire logic [5:0]  avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic        arith_exc,
   input wire logic        carry_clear,
   input wire logic        instr_retire,
   input wire logic        procedure_return_instr,
   input wire logic        mem_waitrequest,
   // watched outputs
   input wire logic        mem_read,
   input wire logic        mem_write,
   input wire logic [31:0] mem_address,
   input wire logic [15:0] mem_writedata,
   input wire logic        redirect_valid,
   input wire logic        int_block,
   input wire logic        segmented_v_mode,
   input wire logic        busy,
   input wire logic        carry_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire clr_w = carry_clear | (avs_write & (avs_address == 6'h08) & avs_writedata[0]);
   sequence s_ret;
      procedure_return_instr && !busy && ce;
   endsequence
   sequence s_nowr;
      !mem_write [*2];
   endsequence
   property p_carry_set;
      arith_exc && ce |=> carry_flag;
   endproperty
   a_carry_set: assert property (p_carry_set) else $error("carry not set");
   property p_carry_hold;
      carry_flag && !clr_w |=> carry_flag;
   endproperty
   a_carry_hold: assert property (p_carry_hold) else $error("carry lost");
   property p_ret;
      s_ret |-> ##[1:60] redirect_valid;
   endproperty
   a_ret: assert property (p_ret) else $error("return not taken");
   property p_redir_pulse;
      redirect_valid |=> !redirect_valid;
   endproperty
   a_redir_pulse: assert property (p_redir_pulse) else $error("redirect too long");
   property p_blk_rise;
      $rose(int_block) |-> redirect_valid;
   endproperty
   a_blk_rise: assert property (p_blk_rise) else $error("block without redirect");
   property p_blk_hold;
      int_block && !instr_retire |=> int_block;
   endproperty
   a_blk_hold: assert property (p_blk_hold) else $error("block dropped early");
   property p_blk_clr;
      int_block && instr_retire && ce |=> !int_block || redirect_valid;
   endproperty
   a_blk_clr: assert property (p_blk_clr) else $error("block outlived instruction");
   property p_mem_busy;
      mem_read || mem_write |-> busy;
   endproperty
   a_mem_busy: assert property (p_mem_busy) else $error("memory access while idle");
   property p_mem_hold;
      (mem_read || mem_write) && mem_waitrequest |=>
         $stable({mem_read, mem_write, mem_address, mem_writedata});
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory beat changed");
   property p_mode;
      $rose(segmented_v_mode) |-> s_nowr;
   endproperty
   a_mode: assert property (p_mode) else $error("frame write after mode");
endmodule : fdu_chk
bind fault_dispatch_unit fdu_chk u_fdu_chk (.sys_clk, .reset, .ce, .avs_write, .avs_address,
   .avs_writedata, .arith_exc, .carry_clear, .instr_retire, .procedure_return_instr,
   .mem_waitrequest, .mem_read, .mem_write, .mem_address, .mem_writedata, .redirect_valid,
   .int_block, .segmented_v_mode, .busy, .carry_flag);
`default_nettype wire

// ==== testbench/fdu_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdu_mem (
   // clock and control
   input wire logic        sys_clk,
   input wire logic        slow,
   // memory port
   input wire logic        mem_read,
   input wire logic        mem_write,
   input wire logic [31:0] mem_address,
   input wire logic [15:0] mem_writedata,
   output logic      [15:0] mem_readdata,
   output logic             mem_waitrequest
);
   logic [15:0] mem [0:255];
   logic        stall;
   initial stall = 1'b1;
   // one stall cycle per beat when slow
   assign mem_waitrequest = slow & stall & (mem_read | mem_write);
   // data only valid in the answer cycle
   assign mem_readdata = (mem_read & !mem_waitrequest) ? mem[mem_address[7:0]]
                                                       : ~mem[mem_address[7:0]];
   always @(posedge sys_clk) begin
      stall <= (mem_read | mem_write) ? ~stall : 1'b1;
      if (mem_write & !mem_waitrequest) begin
         mem[mem_address[7:0]] <= mem_writedata;
      end
   end
endmodule : fdu_mem
`default_nettype wire

// ==== testbench/test_fault_dispatch_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_fault_dispatch_unit;
   logic        sys_clk, reset, ce, avs_read, avs_write, slow, avs_waitrequest;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, cur_pc, fault_info_addr, arith_addr;
   logic [31:0] mem_address, redirect_pc, rdv;
   logic [15:0] proc_blk_word4, fault_info_code, mem_writedata, mem_readdata;
   logic [14:0] ev;
   logic [3:0]  arith_sel;
   logic        page_present, access_ok, seg_out_range, seg_absent, ptr_fault_bit;
   logic        mem_read, mem_write, mem_waitrequest, redirect_valid;
   logic        int_block, segmented_v_mode, busy, carry_flag;
   int          mismatches, checks;
   localparam logic [15:0] codes [16] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0500,
      16'h0200, 16'h0201, 16'h0600, 16'h0300, 16'h0301, 16'h0700, 16'h0701, 16'h0702,
      16'h0800, 16'h0801, 16'h0803};
   localparam int fidx [11] = '{0, 1, 2, 3, 5, 6, 2, 7, 9, 2, 10};
   localparam logic [3:0] cs [3] = '{4'h0, 4'h8, 4'ha};
   fault_dispatch_unit u_fault_dispatch_unit (.sys_clk, .reset, .ce, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_read, .mem_write,
      .mem_address, .mem_writedata, .mem_readdata, .mem_waitrequest, .cur_pc,
      .priv_instr(ev[0]), .dispatch(ev[1]), .proc_blk_word4, .xlate_ref(ev[2]), .page_present,
      .access_ok, .seg_out_range, .seg_absent, .decode_unimpl(ev[3]), .decode_illegal(ev[6]),
      .sem_overflow(ev[4]), .sem_underflow(ev[5]), .stack_over(ev[8]), .stack_under(ev[9]),
      .arg_ptr(ev[10]), .ptr_fault_bit, .fault_info_code, .fault_info_addr,
      .arith_exc(ev[7]), .arith_sel, .arith_addr, .carry_clear(ev[11]),
      .fault_call_instr(ev[12]), .procedure_return_instr(ev[13]), .instr_retire(ev[14]),
      .redirect_valid, .redirect_pc, .int_block, .segmented_v_mode, .busy, .carry_flag);
   fdu_mem u_fdu_mem (.sys_clk, .slow, .mem_read, .mem_write, .mem_address, .mem_writedata,
      .mem_readdata, .mem_waitrequest);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [15:0] m(input logic [7:0] a);
      return u_fdu_mem.mem[a];
   endfunction : m
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask : rd_chk
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev <= '0;
   endtask : pulse
   task automatic fault(input int t);
      proc_blk_word4 <= {15'h0, t == 1};
      page_present <= t != 2;
      access_ok <= t != 6;
      seg_out_range <= t == 9;
      ptr_fault_bit <= t == 10;
      pulse(fidx[t]);
      {proc_blk_word4, seg_out_range, ptr_fault_bit} <= '0;
      {page_present, access_ok} <= 2'b11;
   endtask : fault
   task automatic wait_redir;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (redirect_valid !== 1'b1 && n < 300);
      chk(redirect_valid, 32'h1);
   endtask : wait_redir
   task automatic t_off;
      bus(1'b1, 6'h1c, 32'h40);
      for (int t = 0; t < 11; t++) begin
         if (t == 7) continue;
         bus(1'b1, 6'h00, {27'h0, t[0], 4'h6});
         cur_pc <= 32'h1000 + t;
         fault_info_code <= 16'(16'h0c00 + t);
         fault(t);
         wait_redir;
         chk(redirect_pc, 32'h0a00 + t);
         chk(int_block, t % 2);
         pulse(14);
         rd_chk(6'h08, t << 4);
         rd_chk(6'h18, 32'h1000 + t);
         rd_chk(6'h0c, 32'h0c00 + t);
      end
   endtask : t_off
   task automatic t_arith;
      bus(1'b1, 6'h04, 32'h0900);
      for (int s = 0; s < 16; s++) begin
         arith_sel <= s[3:0];
         arith_addr <= 32'h2000 + s;
         pulse(7);
         wait_redir;
         chk(redirect_pc, 32'h0a07);
         rd_chk(6'h0c, codes[s]);
         rd_chk(6'h10, 32'h28);
         rd_chk(6'h14, s == 8 ? 0 : 32'h2000 + s);
         pulse(11);
         @(posedge sys_clk);
         chk(carry_flag, 32'h0);
      end
      bus(1'b1, 6'h04, 32'h0080);
      for (int i = 0; i < 3; i++) begin
         arith_sel <= cs[i];
         pulse(7);
         @(posedge sys_clk);
         chk(busy, 32'h0);
         repeat (4) @(posedge sys_clk);
         chk(carry_flag, 32'h1);
         bus(1'b1, 6'h08, 32'h1);
         chk(carry_flag, 32'h0);
      end
   endtask : t_arith
   task automatic t_on;
      slow <= 1'b1;
      bus(1'b1, 6'h00, 32'h11);
      bus(1'b1, 6'h1c, 32'h60);
      bus(1'b1, 6'h24, 32'h80);
      bus(1'b1, 6'h20, 32'h80);
      bus(1'b1, 6'h28, 32'h86);
      bus(1'b1, 6'h2c, 32'hc0);
      cur_pc <= 32'h00050123;
      fault_info_code <= 16'h0c02;
      fault_info_addr <= 32'h00060456;
      fault(2);
      wait_redir;
      chk(redirect_pc, 32'ha8);
      chk(segmented_v_mode, 32'h1);
      chk({m(8'h80), m(8'h81)}, 32'h00050123);
      chk({m(8'h83), m(8'h85)}, 32'h0c020456);
      rd_chk(6'h20, 32'h86);
      cur_pc <= 32'h00070777;
      fault_info_code <= 16'h0c03;
      fault(3);
      wait_redir;
      chk(redirect_pc, 32'hac);
      rd_chk(6'h20, 32'h80);
      pulse(12);
      wait_redir;
      chk(redirect_pc, 32'h00012345);
      chk({m(8'hc0), m(8'hc3)}, 32'h00010777);
      chk({m(8'hca), m(8'hcc)}, 32'h0c030456);
      rd_chk(6'h20, 32'h86);
      rd_chk(6'h2c, 32'hd0);
      pulse(13);
      wait_redir;
      chk(redirect_pc, 32'h00070777);
   endtask : t_on
   task automatic results;
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      {reset, ce, page_present, access_ok} = 4'hf;
      {avs_read, avs_write, slow, ev, arith_sel, seg_out_range, seg_absent, ptr_fault_bit} = '0;
      {avs_address, avs_writedata, cur_pc, fault_info_addr, arith_addr} = '0;
      {proc_blk_word4, fault_info_code} = '0;
      mismatches = 0;
      checks = 0;
      for (int i = 0; i < 16; i++) u_fdu_mem.mem[8'h40 + i] = 16'(16'h0a00 + i);
      {u_fdu_mem.mem[8'h60], u_fdu_mem.mem[8'h61]} = 32'h000000a0;
      {u_fdu_mem.mem[8'had], u_fdu_mem.mem[8'hae]} = 32'h00012345;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd_chk(6'h08, 32'h0);
      t_off;
      t_arith;
      t_on;
      results;
   end
   initial begin
      #300000;
      mismatches++;
      results;
   end
endmodule : test_fault_dispatch_unit
`default_nettype wire
